// ### fsp_consts.svh
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ============================================================
// Register byte offsets on the APB slave.
`define FSP_OFF_CTRL        8'h00
`define FSP_OFF_UNLOCK      8'h04
`define FSP_OFF_PTR         8'h08
`define FSP_OFF_LATCH       8'h0c
`define FSP_OFF_TBLOP       8'h10
`define FSP_OFF_STATUS      8'h14

// ============================================================
// Field positions.
`define FSP_CTRL_PROG       7
`define FSP_CTRL_CFG        6
`define FSP_CTRL_ERASE      4
`define FSP_CTRL_ABORT      3
`define FSP_CTRL_PROGRAM_WRITE_ENABLE       2
`define FSP_CTRL_START      1
`define FSP_TBLOP_WRITE     0
`define FSP_TBLOP_MODE_LSB  1
`define FSP_STAT_DONE       0
`define FSP_STAT_BUSY       1

// ============================================================
// Unlock keys and reset values.
`define FSP_KEY_FIRST       8'h55
`define FSP_KEY_SECOND      8'haa
`define FSP_HOLD_RESET      8'hff
`define FSP_ERASED_WORD     16'hffff
`define FSP_PTR_RESET       22'h000000
`define FSP_LATCH_RESET     8'h00

// ============================================================
// Erase geometry and long-write timing.
`define FSP_ERASE_LSB       6
`define FSP_ERASE_WORDS     32
`define FSP_CLK_PERIOD_NS   40
`define FSP_LONG_WRITE_NS   2000000
`define FSP_LONG_WRITE_CYCLES \
   ((`FSP_LONG_WRITE_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

// ### fsp_cpu_model.sv
`timescale 1ns/1ns
`include "fsp_consts.svh"
// ============================================================
// Processor model: issues the bus moves behind table and control steps.
module fsp_cpu_model
   import fsp_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata
);
   logic hung;

   // Bus idle from time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      hung = 1'b0;
   end

   // ============================================================
   // One transfer, held until pready is sampled high or 200 cycles pass.
   // Released address and data lines show inverted values so stale data cannot pass.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 200);
      hung = (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask

   // ============================================================
   // Long write: selects first, then both keys, then the start bit.
   // selects before start.
   task automatic longWrite(input logic erase);
      logic [31:0] ctrl;
      logic [31:0] rd;
      logic        err;
      ctrl = 32'h00000084 | (32'(erase) << `FSP_CTRL_ERASE);
      xfer(1'b1, `FSP_OFF_CTRL, ctrl, rd, err);
      xfer(1'b1, `FSP_OFF_UNLOCK, 32'(`FSP_KEY_FIRST), rd, err);
      xfer(1'b1, `FSP_OFF_UNLOCK, 32'(`FSP_KEY_SECOND), rd, err);
      xfer(1'b1, `FSP_OFF_CTRL, ctrl | 32'h00000002, rd, err);
   endtask
endmodule

// ### fsp_pkg.sv
// ============================================================
// Shared types of the flash self-programming controller.
package fsp_pkg;

   // Pointer adjustment chosen by a table instruction.
   typedef enum logic [1:0] {
      PTR_KEEP     = 2'h0,
      PTR_POST_INC = 2'h1,
      PTR_POST_DEC = 2'h2,
      PTR_PRE_INC  = 2'h3
   } fsp_ptr_mode_e;

   // Unlock guard progress, Gray coded.
   typedef enum logic [1:0] {
      ULK_IDLE  = 2'b00,
      ULK_FIRST = 2'b01,
      ULK_ARMED = 2'b11
   } fsp_unlock_e;

   // Long write sequencer, Gray coded.
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_RUN    = 2'b01,
      SEQ_COMMIT = 2'b11
   } fsp_seq_e;

   // Software control bits held in the control register.
   typedef struct packed {
      logic progSel;
      logic cfgSel;
      logic eraseSel;
      logic program_write_enable;
   } fsp_ctrl_s;

   // One APB request as seen by the slave.
   typedef struct packed {
      logic [7:0]  addr;
      logic        write;
      logic [31:0] wdata;
   } fsp_apb_req_s;

endpackage

// ### fsp_self_prog_ctrl.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`include "fsp_consts.svh"
module fsp_self_prog_ctrl
   import fsp_pkg::*;
#(
   parameter int BLOCK_BYTES       = 64,
   parameter int MEM_WORDS         = 512,
   parameter int LONG_WRITE_CYCLES = `FSP_LONG_WRITE_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             cpuStall,
   output logic             writeDoneFlag,
   output logic             writeAbortFlag
);

   // ============================================================
   // Geometry.
   localparam int HB  = $clog2(BLOCK_BYTES);
   localparam int HWB = HB - 1;
   localparam int AW  = $clog2(MEM_WORDS) + 1;
   localparam int EWB = `FSP_ERASE_LSB - 1;
   localparam int TW  = $clog2(LONG_WRITE_CYCLES + 1);

   // ============================================================
   // State.
   fsp_ctrl_s     ctrl_r;
   fsp_unlock_e   unlock_r;
   fsp_seq_e      seqState_r;
   logic          startBit_r;
   logic          abortFlag_r;
   logic          writeDone_r;
   logic          cpuStall_r;
   logic          resetDly_r;
   logic [21:0]   ptr_r;
   logic [7:0]    latch_r;
   logic [TW-1:0] timer_r;
   logic          pready_r;
   logic          pslverr_r;
   logic [31:0]   prdata_r;
   logic [15:0]   flashMem [MEM_WORDS];
   logic [7:0]    holdBytes [BLOCK_BYTES];

   // ============================================================
   // Bus decode.
   fsp_apb_req_s  req;
   logic          setupDone;
   logic          wrAcc;
   logic          wrCtrl;
   logic          wrUnlock;
   logic          wrPtr;
   logic          wrLatch;
   logic          wrStatus;
   logic          tblOp;
   logic          tblWrite;
   logic          tblRead;
   fsp_ptr_mode_e ptrMode;
   logic          startReq;
   logic          properStart;
   logic          improperStart;
   logic [21:0]   effPtr;
   logic [21:0]   ptr_nxt;
   logic [15:0]   readWord;
   logic [7:0]    readByte;
   logic [31:0]   rdata_nxt;
   logic          err_nxt;

   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

   // The access phase waits while a long write runs, which is what halts the core.
   assign setupDone = psel & penable & ~pready_r & (seqState_r == SEQ_IDLE);
   assign wrAcc     = psel & penable & pready_r & req.write;
   assign wrCtrl    = wrAcc & (req.addr == `FSP_OFF_CTRL);
   assign wrUnlock  = wrAcc & (req.addr == `FSP_OFF_UNLOCK);
   assign wrPtr     = wrAcc & (req.addr == `FSP_OFF_PTR);
   assign wrLatch   = wrAcc & (req.addr == `FSP_OFF_LATCH);
   assign wrStatus  = wrAcc & (req.addr == `FSP_OFF_STATUS);
   assign tblOp     = wrAcc & (req.addr == `FSP_OFF_TBLOP);
   assign tblWrite  = tblOp & req.wdata[`FSP_TBLOP_WRITE];
   assign tblRead   = tblOp & ~req.wdata[`FSP_TBLOP_WRITE];
   assign ptrMode   = fsp_ptr_mode_e'(req.wdata[`FSP_TBLOP_MODE_LSB +: 2]);

   assign startReq      = wrCtrl & req.wdata[`FSP_CTRL_START];
   assign properStart   = startReq & (unlock_r == ULK_ARMED) & req.wdata[`FSP_CTRL_PROG]
                        & ~req.wdata[`FSP_CTRL_CFG] & req.wdata[`FSP_CTRL_PROGRAM_WRITE_ENABLE];
   assign improperStart = startReq & ~properStart;

   // ============================================================
   // Table pointer arithmetic; only the low 21 bits ever move.
   always_comb
   begin
      effPtr  = ptr_r;
      ptr_nxt = ptr_r;
      if (ptrMode == PTR_PRE_INC)
         effPtr = {ptr_r[21], ptr_r[20:0] + 21'h000001};
      unique case (ptrMode)
         PTR_KEEP:     ptr_nxt = ptr_r;
         PTR_POST_INC: ptr_nxt = {ptr_r[21], ptr_r[20:0] + 21'h000001};
         PTR_POST_DEC: ptr_nxt = {ptr_r[21], ptr_r[20:0] - 21'h000001};
         PTR_PRE_INC:  ptr_nxt = effPtr;
      endcase
   end

   assign readWord = flashMem[effPtr[AW-1:1]];
   assign readByte = effPtr[0] ? readWord[15:8] : readWord[7:0];

   // Pointer register, written by software or moved by a table instruction.
   always_ff @(posedge core_clk)
   begin
      if (reset)
         ptr_r <= `FSP_PTR_RESET;
      else if (wrPtr)
         ptr_r <= req.wdata[21:0];
      else if (tblOp)
         ptr_r <= ptr_nxt;
   end

   // Table latch; one byte per read, never a wider unit.
   always_ff @(posedge core_clk)
   begin
      if (reset)
         latch_r <= `FSP_LATCH_RESET;
      else if (wrLatch)
         latch_r <= req.wdata[7:0];
      else if (tblRead)
         latch_r <= readByte;
   end

   // ============================================================
   // Holding registers, one per byte of the write block.
   for (genvar gi = 0; gi < BLOCK_BYTES; gi++)
   begin : gHold
      always_ff @(posedge core_clk)
      begin
         if (reset || seqState_r == SEQ_COMMIT)
            holdBytes[gi] <= `FSP_HOLD_RESET;
         else if (tblWrite && effPtr[HB-1:0] == HB'(gi))
            holdBytes[gi] <= latch_r;
      end
   end

   // ============================================================
   // Unlock guard; any other bus write in between disarms it, except a repeated first key, which keeps ULK_FIRST.
   always_ff @(posedge core_clk)
   begin
      if (reset)
         unlock_r <= ULK_IDLE;
      else if (wrAcc)
      begin
         unique case (unlock_r)
            ULK_FIRST:
               unlock_r <= (wrUnlock && req.wdata[7:0] == `FSP_KEY_SECOND) ? ULK_ARMED
                         : (wrUnlock && req.wdata[7:0] == `FSP_KEY_FIRST)  ? ULK_FIRST
                                                                           : ULK_IDLE;
            ULK_IDLE, ULK_ARMED:
               unlock_r <= (wrUnlock && req.wdata[7:0] == `FSP_KEY_FIRST) ? ULK_FIRST : ULK_IDLE;
            default:
               unlock_r <= ULK_IDLE;
         endcase
      end
   end

   // ============================================================
   // Long write sequencer and its timer; the stall covers run and commit.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         seqState_r <= SEQ_IDLE;
         timer_r    <= '0;
         cpuStall_r <= 1'b0;
      end
      else
      begin
         unique case (seqState_r)
            SEQ_IDLE:
               if (properStart)
               begin
                  seqState_r <= SEQ_RUN;
                  timer_r    <= '0;
                  cpuStall_r <= 1'b1;
               end
            SEQ_RUN:
               if (timer_r == TW'(LONG_WRITE_CYCLES - 1))
                  seqState_r <= SEQ_COMMIT;
               else
                  timer_r <= timer_r + TW'(1);
            SEQ_COMMIT:
            begin
               seqState_r <= SEQ_IDLE;
               cpuStall_r <= 1'b0;
            end
            default:
               seqState_r <= SEQ_IDLE;
         endcase
      end
   end

   // ============================================================
   // Flash array. Contents survive reset, so the array has no reset branch.
   // The update lands in one cycle at the end of the timed window.
   always_ff @(posedge core_clk)
   begin
      if (seqState_r == SEQ_COMMIT)
      begin
         if (ctrl_r.eraseSel)
         begin
            for (int w = 0; w < `FSP_ERASE_WORDS; w++)
               flashMem[{ptr_r[AW-1:`FSP_ERASE_LSB], EWB'(w)}] <= `FSP_ERASED_WORD;
         end
         else
         begin
            for (int w = 0; w < BLOCK_BYTES / 2; w++)
               flashMem[{ptr_r[AW-1:HB], HWB'(w)}] <= flashMem[{ptr_r[AW-1:HB], HWB'(w)}]
                                                   & {holdBytes[2*w+1], holdBytes[2*w]};
         end
      end
   end

   // ============================================================
   // Reset level at the previous edge, so a long reset keeps the cut that it found.
   always_ff @(posedge core_clk)
      resetDly_r <= reset;

   // Control register: selects, start and abort flag.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ctrl_r      <= '0;
         startBit_r  <= 1'b0;
         // reset during a long write
         // The sequencer is idle after the first reset edge, so later edges keep the flag.
         if (seqState_r != SEQ_IDLE)
            abortFlag_r <= 1'b1;
         else if (resetDly_r)
            abortFlag_r <= abortFlag_r;
         else
            abortFlag_r <= 1'b0;
      end
      else if (wrCtrl)
      begin
         ctrl_r.progSel  <= req.wdata[`FSP_CTRL_PROG];
         ctrl_r.cfgSel   <= req.wdata[`FSP_CTRL_CFG];
         ctrl_r.eraseSel <= req.wdata[`FSP_CTRL_ERASE];
         ctrl_r.program_write_enable     <= req.wdata[`FSP_CTRL_PROGRAM_WRITE_ENABLE];
         startBit_r      <= properStart;
         abortFlag_r     <= req.wdata[`FSP_CTRL_ABORT] | improperStart;
      end
      else if (seqState_r == SEQ_COMMIT)
      begin
         startBit_r      <= 1'b0;
         ctrl_r.eraseSel <= 1'b0;
         abortFlag_r     <= 1'b0;
      end
   end

   // Sticky completion flag; completion wins over a write-one-to-clear.
   always_ff @(posedge core_clk)
   begin
      if (reset)
         writeDone_r <= 1'b0;
      else if (seqState_r == SEQ_COMMIT)
         writeDone_r <= 1'b1;
      else if (wrStatus && req.wdata[`FSP_STAT_DONE])
         writeDone_r <= 1'b0;
   end

   // ============================================================
   // Read data; the unlock and table-op registers read as zero.
   always_comb
   begin
      rdata_nxt = 32'h00000000;
      err_nxt   = 1'b0;
      case (req.addr)
         `FSP_OFF_CTRL:
            rdata_nxt = {24'h000000, ctrl_r.progSel, ctrl_r.cfgSel, 1'b0, ctrl_r.eraseSel,
                         abortFlag_r, ctrl_r.program_write_enable, startBit_r, 1'b0};
         `FSP_OFF_UNLOCK: rdata_nxt = 32'h00000000;
         `FSP_OFF_PTR:    rdata_nxt = {10'h000, ptr_r};
         `FSP_OFF_LATCH:  rdata_nxt = {24'h000000, latch_r};
         `FSP_OFF_TBLOP:  rdata_nxt = 32'h00000000;
         `FSP_OFF_STATUS: rdata_nxt = {30'h00000000, cpuStall_r, writeDone_r};
         default:         err_nxt   = 1'b1;
      endcase
   end

   // APB answer: one wait state, longer while the sequencer is busy.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end
      else
      begin
         pready_r <= setupDone;
         if (setupDone)
         begin
            pslverr_r <= err_nxt;
            prdata_r  <= rdata_nxt;
         end
      end
   end

   assign prdata         = prdata_r;
   assign pready         = pready_r;
   assign pslverr        = pslverr_r;
   assign cpuStall       = cpuStall_r;
   assign writeDoneFlag  = writeDone_r;
   assign writeAbortFlag = abortFlag_r;

   // ============================================================
   // Checks.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_UNGUARDED_START: assert property (improperStart |=> seqState_r == SEQ_IDLE)
      else $error("Start without unlock began a long write.");
   AST_GUARDED_START: assert property (properStart |=> cpuStall_r && seqState_r == SEQ_RUN)
      else $error("Guarded start did not begin a long write.");
   AST_STALL_HOLD: assert property ((seqState_r == SEQ_RUN
                                     && timer_r != TW'(LONG_WRITE_CYCLES - 1))
                                    |=> cpuStall_r && seqState_r == SEQ_RUN && !pready_r)
      else $error("Stall ended before the timer expired.");
   AST_STALL_END: assert property ($rose(seqState_r == SEQ_COMMIT) |-> cpuStall_r
                                   ##1 !cpuStall_r && seqState_r == SEQ_IDLE)
      else $error("Stall did not end right after commit.");
   AST_START_CLEAR: assert property (seqState_r == SEQ_COMMIT |=> !startBit_r)
      else $error("Start bit still set after completion.");
   AST_DONE_SET: assert property (seqState_r == SEQ_COMMIT |=> writeDone_r [*2])
      else $error("Write-done flag not set or not sticky.");
   AST_HOLD_CLEAR: assert property (seqState_r == SEQ_COMMIT
                                    |=> holdBytes[0] == `FSP_HOLD_RESET)
      else $error("Holding register not restored after write.");
   AST_ABORT_SET: assert property (improperStart |=> abortFlag_r)
      else $error("Improper start did not flag abort.");
   AST_PTR_POSTINC: assert property (tblOp && ptrMode == PTR_POST_INC
                                     |=> ptr_r[20:0] == $past(ptr_r[20:0]) + 21'h000001)
      else $error("Post-increment did not advance the pointer.");
   AST_ERASE_BLOCK: assert property (seqState_r == SEQ_COMMIT && ctrl_r.eraseSel
                                     |=> flashMem[{$past(ptr_r[AW-1:`FSP_ERASE_LSB]), EWB'(0)}]
                                         == `FSP_ERASED_WORD)
      else $error("Erase left the block base word programmed.");

endmodule

// ### testbench.sv
`timescale 1ns/1ns
`include "fsp_consts.svh"
// ============================================================
// Self-checking bench of the flash self-programming controller.
module testbench
   import fsp_pkg::*;
();
   localparam int LWC = 20;
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        err;
   } fsp_row_s;
   logic          core_clk;
   logic          reset;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic    [7:0] paddr;
   logic   [31:0] pwdata;
   logic   [31:0] prdata;
   logic          pready;
   logic          pslverr;
   logic          cpuStall;
   logic          writeDoneFlag;
   logic          writeAbortFlag;
   logic   [31:0] rdv;
   logic          lastErr;
   logic    [7:0] fl [0:127];
   int            miscompares;
   int            checks_done;
   fsp_ptr_mode_e modes [0:3] = '{PTR_POST_DEC, PTR_PRE_INC, PTR_KEEP, PTR_POST_INC};
   int            ptrAfter [0:3] = '{0, 1, 1, 2};
   fsp_row_s      rows [0:11] = '{
      '{1'b0, `FSP_OFF_PTR, 32'h0, 32'h0, 1'b0},
      '{1'b0, `FSP_OFF_LATCH, 32'h0, 32'h0, 1'b0},
      '{1'b1, `FSP_OFF_PTR, 32'hffffffff, 32'h0, 1'b0},
      '{1'b0, `FSP_OFF_PTR, 32'h0, 32'h003fffff, 1'b0},
      '{1'b1, `FSP_OFF_LATCH, 32'h000001a5, 32'h0, 1'b0},
      '{1'b0, `FSP_OFF_LATCH, 32'h0, 32'h000000a5, 1'b0},
      '{1'b0, `FSP_OFF_UNLOCK, 32'h0, 32'h0, 1'b0},
      '{1'b0, `FSP_OFF_TBLOP, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h1c, 32'hffffffff, 32'h0, 1'b1},
      '{1'b1, `FSP_OFF_CTRL, 32'h00000094, 32'h0, 1'b0},
      '{1'b0, `FSP_OFF_CTRL, 32'h0, 32'h00000094, 1'b0}};

   fsp_self_prog_ctrl #(.BLOCK_BYTES(64), .MEM_WORDS(64), .LONG_WRITE_CYCLES(LWC)) i_dut (
      .core_clk       (core_clk),
      .reset          (reset),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .cpuStall       (cpuStall),
      .writeDoneFlag  (writeDoneFlag),
      .writeAbortFlag (writeAbortFlag));

   fsp_cpu_model i_cpu (
      .core_clk (core_clk),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata));

   // Free-running 25 MHz clock.
   always #20 core_clk = ~core_clk;

   // ============================================================
   // Comparison, verdict and bus helpers.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // A hung transfer ends the run at once.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      i_cpu.xfer(wr, a, d, rdv, lastErr);
      if (i_cpu.hung)
      begin
         miscompares++;
         print_verdict();
      end
   endtask

   task automatic tblRead(input fsp_ptr_mode_e m, input int idx);
      bus(1'b1, `FSP_OFF_TBLOP, {29'h0, m, 1'b0});
      bus(1'b0, `FSP_OFF_LATCH, 32'h0);
      check("latch byte", rdv, 32'(fl[idx]));
   endtask

   task automatic tblWrite(input fsp_ptr_mode_e m, input logic [7:0] b);
      bus(1'b1, `FSP_OFF_LATCH, 32'(b));
      bus(1'b1, `FSP_OFF_TBLOP, {29'h0, m, 1'b1});
   endtask

   // Stall must last the timer count plus the commit cycle.
   task automatic longRun(input logic erase);
      int n;
      i_cpu.longWrite(erase);
      n = 0;
      #1;
      while (cpuStall === 1'b1 && n < 200)
      begin
         n++;
         @(posedge core_clk);
         #1;
      end
      check("stall cycles", 32'(n), 32'(LWC + 1));
      check("done flag", 32'(writeDoneFlag), 32'h1);
      if (n >= 200 || i_cpu.hung)
         print_verdict();
   endtask

   // ============================================================
   // Main sequence.
   initial
   begin
      core_clk = 1'b0;
      reset = 1'b1;
      miscompares = 0;
      checks_done = 0;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      #1;
      check("reset outputs", 32'({pready, cpuStall, writeDoneFlag, writeAbortFlag}), 32'h0);
      for (int i = 0; i < 12; i++)
      begin
         bus(rows[i].wr, rows[i].addr, rows[i].wdata);
         check("slave error", 32'(lastErr), 32'(rows[i].err));
         if (!rows[i].wr)
            check("read data", rdv, rows[i].rdata);
      end
      // Erase both blocks; low pointer bits are ignored.
      bus(1'b1, `FSP_OFF_PTR, 32'h0000003f);
      longRun(1'b1);
      bus(1'b0, `FSP_OFF_CTRL, 32'h0);
      check("control after erase", rdv, 32'h00000084);
      bus(1'b1, `FSP_OFF_STATUS, 32'h00000001);
      bus(1'b0, `FSP_OFF_STATUS, 32'h0);
      check("status cleared", rdv, 32'h0);
      bus(1'b1, `FSP_OFF_PTR, 32'h00000040);
      longRun(1'b1);
      for (int i = 0; i < 128; i++)
         fl[i] = 8'hff;
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      for (int i = 0; i < 4; i++)
         tblRead(PTR_POST_INC, i);
      bus(1'b0, `FSP_OFF_PTR, 32'h0);
      check("pointer", rdv, 32'h4);
      // Load three holding bytes; high pointer bits do not matter.
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      tblWrite(PTR_POST_INC, 8'h12);
      tblWrite(PTR_POST_INC, 8'h34);
      bus(1'b1, `FSP_OFF_PTR, 32'h00000043);
      tblWrite(PTR_KEEP, 8'h56);
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      tblRead(PTR_KEEP, 0);
      bus(1'b1, `FSP_OFF_PTR, 32'h00000005);
      longRun(1'b0);
      fl[0] = 8'h12;
      fl[1] = 8'h34;
      fl[3] = 8'h56;
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      for (int i = 0; i < 6; i++)
         tblRead(PTR_POST_INC, i);
      bus(1'b1, `FSP_OFF_PTR, 32'h00000043);
      tblRead(PTR_KEEP, 67);
      // Reprogram one byte; bits only clear, reloaded holding stays FFh.
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      tblWrite(PTR_KEEP, 8'hf0);
      longRun(1'b0);
      fl[0] = 8'h10;
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      tblRead(PTR_POST_INC, 0);
      tblRead(PTR_POST_INC, 1);
      // Every pointer mode, starting on the high byte of word zero.
      bus(1'b1, `FSP_OFF_PTR, 32'h00000001);
      for (int k = 0; k < 4; k++)
      begin
         tblRead(modes[k], 1);
         bus(1'b0, `FSP_OFF_PTR, 32'h0);
         check("pointer mode", rdv, 32'(ptrAfter[k]));
      end
      // Program a byte of block one, then erase block one only; block zero keeps its data.
      bus(1'b1, `FSP_OFF_PTR, 32'h00000043);
      tblWrite(PTR_KEEP, 8'h0f);
      longRun(1'b0);
      fl[67] = 8'h0f;
      tblRead(PTR_KEEP, 67);
      bus(1'b1, `FSP_OFF_PTR, 32'h0000007f);
      longRun(1'b1);
      fl[67] = 8'hff;
      bus(1'b1, `FSP_OFF_PTR, 32'h00000043);
      tblRead(PTR_KEEP, 67);
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      tblRead(PTR_KEEP, 0);
      // A broken key sequence must not start anything.
      bus(1'b1, `FSP_OFF_CTRL, 32'h00000084);
      bus(1'b1, `FSP_OFF_UNLOCK, 32'h00000055);
      bus(1'b1, `FSP_OFF_PTR, 32'h0);
      bus(1'b1, `FSP_OFF_UNLOCK, 32'h000000aa);
      bus(1'b1, `FSP_OFF_CTRL, 32'h00000086);
      repeat (2) @(posedge core_clk);
      #1;
      check("no stall", 32'(cpuStall), 32'h0);
      check("abort flag", 32'(writeAbortFlag), 32'h1);
      tblRead(PTR_KEEP, 0);
      // Reset in the middle of an erase.
      bus(1'b1, `FSP_OFF_PTR, 32'h00000040);
      i_cpu.longWrite(1'b1);
      repeat (5) @(posedge core_clk);
      #1;
      check("abort cleared", 32'(writeAbortFlag), 32'h0);
      check("stalling", 32'(cpuStall), 32'h1);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      #1;
      check("abort after reset", 32'(writeAbortFlag), 32'h1);
      check("stall after reset", 32'(cpuStall), 32'h0);
      print_verdict();
   end
endmodule
